// >>> pkg/dcgh_cfg.svh
// Constants for the domain clock-gating handshake: counts, widths and reset levels
`ifndef DCGH_CFG_SVH
`define DCGH_CFG_SVH

// ------------------------------------------------------------------
// Structure
// ------------------------------------------------------------------
`define DCGH_N_DOM        2
`define DCGH_CNT_W        4
`define DCGH_SYNC_STAGES  3

// ------------------------------------------------------------------
// Reset levels of the low-power channel and the clock enable
// ------------------------------------------------------------------
`define DCGH_REQ_RST      1'b1
`define DCGH_ACK_RST      1'b1
`define DCGH_ACT_RST      1'b0
`define DCGH_CLKEN_RST    1'b1

`endif

// >>> pkg/dcgh_pkg.sv
// Types shared by both ends of the domain clock-gating handshake
package dcgh_pkg;

   // ------------------------------------------------------------------
   // Device end, one per clock domain (Gray along run-drain-stop)
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      DCGH_DEV_RUN   = 2'b00,
      DCGH_DEV_DRAIN = 2'b01,
      DCGH_DEV_STOP  = 2'b11
   } dcgh_dev_state_t;

   // ------------------------------------------------------------------
   // Register routing path of the central domain
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      DCGH_REG_IDLE = 2'b00,
      DCGH_REG_WAIT = 2'b01,
      DCGH_REG_FWD  = 2'b11
   } dcgh_reg_state_t;

   // ------------------------------------------------------------------
   // Controller end, one per clock domain
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      DCGH_CTL_ON   = 2'b00,
      DCGH_CTL_REQ  = 2'b01,
      DCGH_CTL_OFF  = 2'b11,
      DCGH_CTL_WAKE = 2'b10
   } dcgh_ctl_state_t;

endpackage

// >>> pkg/dcgh_lp_if.sv
// Low-power channels between the interconnect domains and the clock controller
`timescale 1ns/1ps
interface dcgh_lp_if #(
   parameter int ND = 3
);
   logic [ND-1:0] csysreq;   // Controller to domain, low asks for gating
   logic [ND-1:0] csysack;   // Domain to controller, follows csysreq
   logic [ND-1:0] cactive;   // Domain to controller, high while busy

   modport dev (
      input  csysreq,
      output csysack,
      output cactive
   );

   modport ctl (
      output csysreq,
      input  csysack,
      input  cactive
   );
endinterface

// >>> rtl/dcgh_sync.sv
// Three-stage synchroniser whose output moves once stages two and three agree
`timescale 1ns/1ps
module dcgh_sync #(
   parameter int          W       = 1,
   parameter logic        RST_VAL = 1'b0
) (
   // Clock and reset
   input  wire logic          sys_clk,
   input  wire logic          rst,
   // Data
   input  wire logic [W-1:0]  d,
   output logic      [W-1:0]  q
);

   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   // First stage feeds only the second, so metastability never reaches logic
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s1_r <= {W{RST_VAL}};
         s2_r <= {W{RST_VAL}};
         s3_r <= {W{RST_VAL}};
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // Filtered output: a bit moves only when two settled samples agree
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         q <= {W{RST_VAL}};
      end else begin
         q <= (s2_r & ~(s2_r ^ s3_r)) | (q & (s2_r ^ s3_r));
      end
   end

endmodule // dcgh_sync

// >>> rtl/dcgh_ctl_end.sv
// Clock controller end: requests gating per domain and enables its clock
`timescale 1ns/1ps
`include "dcgh_cfg.svh"
module dcgh_ctl_end
   import dcgh_pkg::*;
#(
   parameter int N_DOM = `DCGH_N_DOM
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst,
   // Low-power channels, last entry is the register routing domain
   dcgh_lp_if.ctl                lp,
   // User side, one bit per domain
   input  wire logic [N_DOM:0]   sleep_req,
   output logic      [N_DOM:0]   dom_clk_en,
   output logic      [N_DOM:0]   dom_off
);

   localparam int ND = N_DOM + 1;

   if (N_DOM < 1) begin : g_chk_dom
      $error("dcgh_ctl_end needs at least one domain");
   end

   logic [ND-1:0]    ack_s;
   logic [ND-1:0]    act_s;
   logic [ND-1:0]    req_r;
   dcgh_ctl_state_t  st_r [ND];

   // ------------------------------------------------------------------
   // Channel inputs come from other clock domains
   // ------------------------------------------------------------------
   dcgh_sync #(.W(ND), .RST_VAL(`DCGH_ACK_RST)) u_ack_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .d       (lp.csysack),
      .q       (ack_s)
   );

   dcgh_sync #(.W(ND), .RST_VAL(`DCGH_ACT_RST)) u_act_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .d       (lp.cactive),
      .q       (act_s)
   );

   assign lp.csysreq = req_r;

   // ------------------------------------------------------------------
   // Per-domain handshake
   // ------------------------------------------------------------------
   // Activity from the domain wins over a sleep request, which wakes it for the
   // register routing domain without software involvement
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < ND; i++) begin
         if (rst) begin
            st_r[i]       <= DCGH_CTL_ON;
            req_r[i]      <= `DCGH_REQ_RST;
            dom_clk_en[i] <= `DCGH_CLKEN_RST;
            dom_off[i]    <= 1'b0;
         end else begin
            case (st_r[i])
               DCGH_CTL_ON: begin
                  if (sleep_req[i] && !act_s[i]) begin
                     req_r[i] <= 1'b0;
                     st_r[i]  <= DCGH_CTL_REQ;
                  end
               end
               DCGH_CTL_REQ: begin
                  // Falling acknowledge always grants; no denial check
                  if (!ack_s[i]) begin
                     dom_clk_en[i] <= 1'b0;
                     dom_off[i]    <= 1'b1;
                     st_r[i]       <= DCGH_CTL_OFF;
                  end
               end
               DCGH_CTL_OFF: begin
                  if (!sleep_req[i] || act_s[i]) begin
                     dom_clk_en[i] <= 1'b1;
                     st_r[i]       <= DCGH_CTL_WAKE;
                  end
               end
               default: begin
                  // Clock restored first, then the request is raised
                  req_r[i] <= 1'b1;
                  if (req_r[i] && ack_s[i]) begin
                     dom_off[i] <= 1'b0;
                     st_r[i]    <= DCGH_CTL_ON;
                  end
               end
            endcase
         end
      end
   end

endmodule // dcgh_ctl_end

// >>> rtl/dcgh_dev_end.sv
// Interconnect end: per-domain gating handshake plus a register routing domain
//
// Behaviour
// - Channel: activity and acknowledge out, request in
// - One low-power channel for every clock domain
// - AHB slave ports each own a domain
// - Block entry on request, then wait until nothing outstanding
// - Acknowledge low only after blocking completes
// - Controller gates clock when acknowledge falls
// - No denial; falling acknowledge always grants
// - Activity output high while busy, low idle
// - System ensures AHB port idle before gating
// - Extra domain routes register accesses to owners
// - Routing domain wakes owners; accesses always succeed
// - Routing domain channel wired to a controller
// - All cross-domain signalling uses asynchronous crossings
// - System keeps foreign APB clocks running
`timescale 1ns/1ps
`include "dcgh_cfg.svh"
module dcgh_dev_end
   import dcgh_pkg::*;
#(
   parameter int N_DOM = `DCGH_N_DOM,
   parameter int CNT_W = `DCGH_CNT_W,
   parameter int DW    = (N_DOM > 1) ? $clog2(N_DOM) : 1
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst,
   // Low-power channels, entry N_DOM belongs to the routing domain
   dcgh_lp_if.dev                lp,
   // Transaction entry per domain
   input  wire logic [N_DOM-1:0] txn_valid,
   output logic      [N_DOM-1:0] txn_ready,
   input  wire logic [N_DOM-1:0] txn_done,
   // Status per domain
   output logic      [N_DOM:0]   dom_busy,
   output logic      [N_DOM:0]   dom_blocked,
   // Register access from software side
   input  wire logic             reg_valid,
   input  wire logic [DW-1:0]    reg_dom,
   output logic                  reg_ready,
   output logic                  reg_done,
   // Register access forwarded to the owning domain
   output logic                  reg_fwd_valid,
   output logic      [DW-1:0]    reg_fwd_dom,
   input  wire logic             reg_fwd_done
);

   localparam int ND = N_DOM + 1;
   localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

   // ------------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------------
   if (N_DOM < 1) begin : g_chk_dom
      $error("dcgh_dev_end needs at least one domain");
   end
   if (CNT_W < 1) begin : g_chk_cnt
      $error("dcgh_dev_end counter width must be positive");
   end
   if (DW < 1 || (1 << DW) < N_DOM) begin : g_chk_dw
      $error("dcgh_dev_end reg_dom too narrow");
   end

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   logic [ND-1:0]      req_s;
   logic [ND-1:0]      ack_r;
   logic [ND-1:0]      act_r;
   logic [ND-1:0]      idle;
   logic [ND-1:0]      want;
   dcgh_dev_state_t    st_r   [ND];
   dcgh_dev_state_t    st_nxt [ND];
   logic [CNT_W-1:0]   cnt_r   [N_DOM];
   logic [CNT_W-1:0]   cnt_nxt [N_DOM];
   logic [N_DOM-1:0]   accept;
   dcgh_reg_state_t    rs_r;
   logic [DW-1:0]      rtgt_r;
   logic               reg_take;
   logic [N_DOM-1:0]   tmask;

   // Decode a domain index into a one-hot target mask
   function automatic logic [N_DOM-1:0] dom_mask(input logic [DW-1:0] idx);
      logic [N_DOM-1:0] m;
      m = '0;
      for (int k = 0; k < N_DOM; k++) begin
         if (idx == k[DW-1:0]) m[k] = 1'b1;
      end
      return m;
   endfunction

   // ------------------------------------------------------------------
   // Request input crossing
   // ------------------------------------------------------------------
   // Requests arrive from the controller's domain, so each passes a synchroniser
   dcgh_sync #(.W(ND), .RST_VAL(`DCGH_REQ_RST)) u_req_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .d       (lp.csysreq),
      .q       (req_s)
   );

   // Channel outputs straight from flip-flops, one pair per domain
   assign lp.csysack = ack_r;
   assign lp.cactive = act_r;

   // ------------------------------------------------------------------
   // Entry and outstanding count per domain
   // ------------------------------------------------------------------
   // Each domain counts its own traffic, so an AHB port in its own domain
   // is never stopped by another port's gating
   assign accept = txn_valid & txn_ready;

   always_comb begin
      for (int i = 0; i < N_DOM; i++) begin
         cnt_nxt[i] = cnt_r[i];
         if (accept[i] && !(txn_done[i] && cnt_r[i] != '0)) begin
            cnt_nxt[i] = cnt_r[i] + 1'b1;
         end else if (!accept[i] && txn_done[i] && cnt_r[i] != '0) begin
            cnt_nxt[i] = cnt_r[i] - 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < N_DOM; i++) begin
         if (rst) begin
            cnt_r[i] <= '0;
         end else begin
            cnt_r[i] <= cnt_nxt[i];
         end
      end
   end

   // Ready only while running; a full counter also holds entry shut
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < N_DOM; i++) begin
         if (rst) begin
            txn_ready[i] <= 1'b1;
         end else begin
            txn_ready[i] <= (st_nxt[i] == DCGH_DEV_RUN) && (cnt_nxt[i] != CNT_MAX);
         end
      end
   end

   // ------------------------------------------------------------------
   // Quiescence and activity
   // ------------------------------------------------------------------
   // Target mask held in a net, since a select on a call result is not legal
   assign tmask = dom_mask(rtgt_r);

   // A forwarded register access counts as outstanding in its owner domain
   always_comb begin
      for (int i = 0; i < N_DOM; i++) begin
         idle[i] = (cnt_r[i] == '0) && !((rs_r == DCGH_REG_FWD) && tmask[i]);
         want[i] = txn_valid[i] || (cnt_r[i] != '0)
                   || ((rs_r != DCGH_REG_IDLE) && tmask[i]);
      end
      idle[N_DOM] = (rs_r == DCGH_REG_IDLE);
      want[N_DOM] = reg_valid || (rs_r != DCGH_REG_IDLE);
   end

   // Activity asks the controller to keep or restore a clock
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         act_r    <= {ND{`DCGH_ACT_RST}};
         dom_busy <= '0;
      end else begin
         act_r    <= want;
         dom_busy <= want;
      end
   end

   // ------------------------------------------------------------------
   // Low-power handshake per domain
   // ------------------------------------------------------------------
   // A request that returns during draining cancels it without an acknowledge
   always_comb begin
      for (int i = 0; i < ND; i++) begin
         st_nxt[i] = st_r[i];
         case (st_r[i])
            DCGH_DEV_RUN: begin
               if (!req_s[i]) st_nxt[i] = DCGH_DEV_DRAIN;
            end
            DCGH_DEV_DRAIN: begin
               if (req_s[i]) st_nxt[i] = DCGH_DEV_RUN;
               else if (idle[i]) st_nxt[i] = DCGH_DEV_STOP;
            end
            default: begin
               if (req_s[i]) st_nxt[i] = DCGH_DEV_RUN;
            end
         endcase
      end
   end

   // Acknowledge drops only in the stopped state, never as a refusal
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < ND; i++) begin
         if (rst) begin
            st_r[i]        <= DCGH_DEV_RUN;
            ack_r[i]       <= `DCGH_ACK_RST;
            dom_blocked[i] <= 1'b0;
         end else begin
            st_r[i]        <= st_nxt[i];
            ack_r[i]       <= (st_nxt[i] != DCGH_DEV_STOP);
            dom_blocked[i] <= (st_nxt[i] != DCGH_DEV_RUN);
         end
      end
   end

   // ------------------------------------------------------------------
   // Register routing domain
   // ------------------------------------------------------------------
   assign reg_take = reg_valid && reg_ready;

   // Accesses wait for the owner's clock rather than failing
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rs_r          <= DCGH_REG_IDLE;
         rtgt_r        <= '0;
         reg_ready     <= 1'b0;
         reg_done      <= 1'b0;
         reg_fwd_valid <= 1'b0;
         reg_fwd_dom   <= '0;
      end else begin
         reg_done      <= 1'b0;
         reg_fwd_valid <= 1'b0;
         case (rs_r)
            DCGH_REG_IDLE: begin
               reg_ready <= (st_nxt[N_DOM] == DCGH_DEV_RUN) && !reg_take;
               if (reg_take) begin
                  rtgt_r <= reg_dom;
                  rs_r   <= DCGH_REG_WAIT;
               end
            end
            DCGH_REG_WAIT: begin
               reg_ready <= 1'b0;
               // Owner must be running; activity above wakes it if gated
               if ((dom_mask(rtgt_r) & txn_ready) != '0) begin
                  reg_fwd_valid <= 1'b1;
                  reg_fwd_dom   <= rtgt_r;
                  rs_r          <= DCGH_REG_FWD;
               end
            end
            default: begin
               reg_ready <= 1'b0;
               if (reg_fwd_done) begin
                  reg_done <= 1'b1;
                  rs_r     <= DCGH_REG_IDLE;
               end
            end
         endcase
      end
   end

endmodule // dcgh_dev_end

// >>> test/dcgh_sva.sv
// Concurrent checks on the low-power channels joining both ends
`timescale 1ns/1ps
module dcgh_sva #(
   parameter int ND = 3
) (
   // Clock and reset
   input wire logic          sys_clk,
   input wire logic          rst,
   // Low-power channels
   input wire logic [ND-1:0] csysreq,
   input wire logic [ND-1:0] csysack,
   input wire logic [ND-1:0] cactive
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // ------------------------------------------------------------------
   // Handshake steps
   // ------------------------------------------------------------------
   // Eight cycles outlast the three-flop synchroniser, its output filter flop and two decision edges
   sequence s_quiet_sleep(logic r, logic a);
      (!r && !a) [*8];
   endsequence
   sequence s_awake(logic r);
      r [*8];
   endsequence

   // Levels left behind by reset
   a_reset_levels: assert property ($fell(rst) |-> csysreq == '1 && csysack == '1 && cactive == '0)
      else $error("channel levels wrong after reset");

   // Per-domain checks, the last index is the routing domain
   for (genvar i = 0; i < ND; i++) begin : g_dom
      a_ack_fall_req: assert property ($fell(csysack[i]) |-> !$past(csysreq[i], 2))
         else $error("acknowledge fell without a request");
      a_ack_rise_req: assert property ($rose(csysack[i]) |-> csysreq[i] && $past(csysreq[i], 3))
         else $error("acknowledge rose before the request settled");
      a_ack_fall_idle: assert property ($fell(csysack[i]) |-> !cactive[i])
         else $error("acknowledge fell while the domain is busy");
      a_req_fall_awake: assert property ($fell(csysreq[i]) |-> csysack[i])
         else $error("request lowered to a stopped domain");
      a_gate_granted: assert property (s_quiet_sleep(csysreq[i], cactive[i]) |-> !csysack[i])
         else $error("quiet domain never acknowledged");
      a_wake_granted: assert property (s_awake(csysreq[i]) |-> csysack[i])
         else $error("domain did not wake on request");
      a_ack_stays_low: assert property (!csysack[i] && !csysreq[i] && !$past(csysreq[i])
            && !$past(csysreq[i], 2) |=> !csysack[i])
         else $error("acknowledge withdrawn while request still low");
   end
endmodule // dcgh_sva

// >>> test/test_domain_clock_gating_handshake.sv
// Self-checking bench: both ends joined, user sides driven and watched
`timescale 1ns/1ps
module test_domain_clock_gating_handshake
   import dcgh_pkg::*;
;
   // ------------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------------
   logic       sys_clk = 1'b0;
   logic       rst = 1'b1;
   logic [1:0] txn_valid = 2'b00;
   logic [1:0] txn_done = 2'b00;
   logic [1:0] txn_ready;
   logic [2:0] dom_busy, dom_blocked, dom_clk_en, dom_off;
   logic [2:0] sleep_req = 3'b000;
   logic       reg_valid = 1'b0;
   logic [0:0] reg_dom = 1'b0;
   logic [0:0] reg_fwd_dom;
   logic       reg_ready, reg_done, reg_fwd_valid;
   logic       reg_fwd_done = 1'b0;
   logic [1:0] fwd_dly = 2'b00;
   logic [0:0] exp_q[$];
   logic [0:0] e;
   int         bad_count = 0;
   int         comparisons = 0;
   int         d, k, j;

   always #20 sys_clk = ~sys_clk;

   // ------------------------------------------------------------------
   // Both ends and the checker
   // ------------------------------------------------------------------
   dcgh_lp_if #(.ND(3)) lp_if_inst ();
   dcgh_dev_end #(.N_DOM(2)) dcgh_dev_end_inst (.sys_clk(sys_clk), .rst(rst), .lp(lp_if_inst),
      .txn_valid(txn_valid), .txn_ready(txn_ready), .txn_done(txn_done), .dom_busy(dom_busy),
      .dom_blocked(dom_blocked), .reg_valid(reg_valid), .reg_dom(reg_dom), .reg_ready(reg_ready),
      .reg_done(reg_done), .reg_fwd_valid(reg_fwd_valid), .reg_fwd_dom(reg_fwd_dom), .reg_fwd_done(reg_fwd_done));
   dcgh_ctl_end #(.N_DOM(2)) dcgh_ctl_end_inst (.sys_clk(sys_clk), .rst(rst), .lp(lp_if_inst),
      .sleep_req(sleep_req), .dom_clk_en(dom_clk_en), .dom_off(dom_off));
   dcgh_sva #(.ND(3)) dcgh_sva_inst (.sys_clk(sys_clk), .rst(rst), .csysreq(lp_if_inst.csysreq),
      .csysack(lp_if_inst.csysack), .cactive(lp_if_inst.cactive));

   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task automatic results();
      if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input bit ok, input string msg);
      comparisons++;
      if (!ok) begin
         bad_count++;
         $display("Error at %0t ns: %s", $time, msg);
      end
   endtask

   // Bounded wait for the controller to report a domain off or on
   task automatic wait_off(input int dd, input logic v);
      int n;
      for (n = 0; n < 100 && dom_off[dd] !== v; n++) @(negedge sys_clk);
      if (n == 100) begin
         check(1'b0, "timeout on domain off flag");
         results();
      end
   endtask

   task automatic sleep_dom(input int dd);
      sleep_req[dd] = 1'b1;
      wait_off(dd, 1'b1);
      check(lp_if_inst.csysack[dd] === 1'b0, "acknowledge not low when off");
      check(dom_clk_en[dd] === 1'b0, "clock still enabled after acknowledge");
      check(dom_blocked[dd] === 1'b1, "domain not blocked");
      if (dd < 2) check(txn_ready[dd] === 1'b0, "entry open while gated");
   endtask

   task automatic wake_dom(input int dd);
      sleep_req[dd] = 1'b0;
      wait_off(dd, 1'b0);
      check(lp_if_inst.csysack[dd] === 1'b1 && dom_blocked[dd] === 1'b0, "no wake");
      if (dd < 2) check(txn_ready[dd] === 1'b1, "entry closed after wake");
   endtask

   // Hold valid until kk transfers were accepted, back to back
   task automatic send_txn(input int dd, input int kk);
      int n, t;
      txn_valid[dd] = 1'b1;
      // Ready seen mid-cycle is what the next rising edge samples
      for (n = 0, t = 0; n < kk && t < 50; t++) begin
         if (txn_ready[dd] === 1'b1) n++;
         @(negedge sys_clk);
      end
      txn_valid[dd] = 1'b0;
      check(n == kk, "transfers not accepted");
   endtask

   task automatic reg_access(input logic [0:0] dd);
      int n;
      reg_valid = 1'b1;
      reg_dom = dd;
      exp_q.push_back(dd);
      for (n = 0; n < 100 && reg_ready !== 1'b1; n++) @(negedge sys_clk);
      @(negedge sys_clk);
      reg_valid = 1'b0;
      for (n = 0; n < 200 && reg_done !== 1'b1; n++) @(negedge sys_clk);
      check(reg_done === 1'b1, "register access never completed");
      if (reg_done !== 1'b1) results();
   endtask

   // ------------------------------------------------------------------
   // Owner model and result watcher
   // ------------------------------------------------------------------
   // The owner answers a forwarded access two cycles later
   always @(negedge sys_clk) begin
      fwd_dly <= {fwd_dly[0], reg_fwd_valid};
      reg_fwd_done <= fwd_dly[1];
   end

   // Forwarded accesses must reach the noted owner while it is awake, seen mid-cycle
   always @(negedge sys_clk) begin
      if (!rst && reg_fwd_valid === 1'b1) begin
         if (exp_q.size() == 0) check(1'b0, "unexpected forwarded access");
         else begin
            e = exp_q.pop_front();
            check(reg_fwd_dom === e, "forwarded to wrong domain");
            check(txn_ready[e] === 1'b1, "owner not awake at forward");
         end
      end
   end

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      void'($urandom(38));
      repeat (4) @(negedge sys_clk);
      rst = 1'b0;
      @(negedge sys_clk);
      check(dom_clk_en === 3'b111 && dom_off === 3'b000 && txn_ready === 2'b11, "reset levels");
      // Every domain, the routing one too, has its own channel
      for (d = 0; d < 3; d++) begin
         sleep_dom(d);
         wake_dom(d);
      end
      // Outstanding transfers hold off the acknowledge
      for (d = 0; d < 2; d++) begin
         k = $urandom_range(1, 4);
         send_txn(d, k);
         sleep_req[d] = 1'b1;
         repeat (20) @(negedge sys_clk);
         check(lp_if_inst.csysack[d] === 1'b1 && dom_clk_en[d] === 1'b1, "gated while busy");
         check(lp_if_inst.cactive[d] === 1'b1 && dom_busy[d] === 1'b1, "activity low while busy");
         repeat (k) begin
            txn_done[d] = 1'b1;
            @(negedge sys_clk);
            txn_done[d] = 1'b0;
            @(negedge sys_clk);
         end
         wait_off(d, 1'b1);
         check(lp_if_inst.cactive[d] === 1'b0 && dom_busy[d] === 1'b0, "activity high while idle");
         wake_dom(d);
      end
      // Register accesses wake a gated owner, which then sleeps again
      sleep_dom(0);
      sleep_dom(1);
      for (j = 0; j < 4; j++) begin
         d = (j == 0) ? 1 : $urandom_range(0, 1);
         reg_access(d[0:0]);
         wait_off(d, 1'b0);
         wait_off(d, 1'b1);
         check(lp_if_inst.csysack[d] === 1'b0, "owner not gated again");
      end
      check(exp_q.size() == 0, "access never forwarded");
      wake_dom(0);
      wake_dom(1);
      results();
   end
endmodule // test_domain_clock_gating_handshake
